// >>> verilog/sdl_latch_top.sv
// set-dominant safety latch function block: latch, state word, diag word
`timescale 1ns/1ns
`include "sdl_cfg.svh"

// What this block does
// - set without reset drives output 1
// - reset without set drives output 0
// - both active: set wins, output 1
// - neither active: output holds previous value
// - each input enabled and polarity selectable
// - both inputs disabled after defaults
// - output safe value 0, stop forces 0
// - 8-bit state; 0 undefined, 2 stop
// - reset only while running reports 3
// - set while running reports 9
// - 16-bit diagnostic word always zero
// - error output never active
// - flags select state/diag into image
module sdl_latch_top (
   // clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // linked inputs, same clock domain
   input wire logic set_i,
   input wire logic reset_i,
   // configuration, taken on cfg_load_i
   input wire logic cfg_load_i,
   input wire logic set_en_i,
   input wire logic set_nc_i,
   input wire logic reset_en_i,
   input wire logic reset_nc_i,
   input wire logic expose_state_word_i,
   input wire logic expose_diag_word_i,
   // group control
   input wire logic block_run_i,
   input wire logic cycle_i,
   // latch result
   output logic latch_out_o,
   output logic [7:0] state_o,
   output logic [15:0] diag_o,
   output logic error_o,
   // cyclic process image
   output logic [7:0] img_state_o,
   output logic [15:0] img_diag_o,
   output logic img_state_vld_o,
   output logic img_diag_vld_o
);

   // =====================================================================
   // configuration registers
   logic [1:0] en_q;
   logic [1:0] nc_q;
   logic map_state_q;
   logic map_diag_q;

   // defaults leave both inputs disabled until software enables them
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         en_q <= `SDL_CFG_EN_RST;
         nc_q <= `SDL_CFG_NC_RST;
         map_state_q <= 1'b0;
         map_diag_q <= 1'b0;
      end else if (cfg_load_i) begin
         en_q[`SDL_CH_SET] <= set_en_i;
         en_q[`SDL_CH_RST] <= reset_en_i;
         nc_q[`SDL_CH_SET] <= set_nc_i;
         nc_q[`SDL_CH_RST] <= reset_nc_i;
         map_state_q <= expose_state_word_i;
         map_diag_q <= expose_diag_word_i;
      end
   end

   // =====================================================================
   // input conditioning
   sdl_chan_if ch ();
   assign ch.raw = {reset_i, set_i};
   assign ch.en = en_q;
   assign ch.nc = nc_q;

   sdl_in_cond u_cond (
      .ch(ch.cond)
   );

   logic set_act;
   logic rst_act;
   assign set_act = ch.act[`SDL_CH_SET];
   assign rst_act = ch.act[`SDL_CH_RST];

   // =====================================================================
   // latch and state
   logic out_q;
   logic out_d;
   sdl_pkg::sdl_state_e state_q;
   sdl_pkg::sdl_state_e state_d;

   // set dominates; a stopped group always drops to the safe value
   always_comb begin
      out_d = out_q;
      state_d = state_q;
      if (!block_run_i) begin
         out_d = `SDL_OUT_RST;
         state_d = sdl_pkg::SDL_ST_STOP;
      end else if (set_act) begin
         out_d = 1'b1;
         state_d = sdl_pkg::SDL_ST_SET;
      end else if (rst_act) begin
         out_d = 1'b0;
         state_d = sdl_pkg::SDL_ST_SAFE;
      end else begin
         out_d = out_q;
         state_d = out_q ? sdl_pkg::SDL_ST_SET : sdl_pkg::SDL_ST_SAFE;
      end
   end

   // only one evaluation per logic cycle; value kept in between
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         out_q <= `SDL_OUT_RST;
         state_q <= sdl_pkg::SDL_ST_UNDEF;
      end else if (cycle_i) begin
         out_q <= out_d;
         state_q <= state_d;
      end
   end

   assign latch_out_o = out_q;
   assign state_o = state_q;

   // =====================================================================
   // diagnostics and error: constant by design, still registered
   always_ff @(posedge clk_i) begin
      diag_o <= `SDL_DIAG_RST;
      error_o <= `SDL_ERR_RST;
   end

   // =====================================================================
   // cyclic process image, refreshed on every clock, one clock behind the state word
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         img_state_o <= 8'h00;
         img_diag_o <= `SDL_DIAG_RST;
         img_state_vld_o <= 1'b0;
         img_diag_vld_o <= 1'b0;
      end else begin
         img_state_vld_o <= map_state_q;
         img_diag_vld_o <= map_diag_q;
         img_state_o <= map_state_q ? state_q : 8'h00;
         img_diag_o <= `SDL_DIAG_RST;
      end
   end

   // =====================================================================
   // checks
   AST_SET_ONLY: assert property (@(posedge clk_i) disable iff (srst_i)
      cycle_i && block_run_i && set_act && !rst_act |=> latch_out_o)
      else $error("set alone did not drive output high");

   AST_RST_ONLY: assert property (@(posedge clk_i) disable iff (srst_i)
      cycle_i && block_run_i && !set_act && rst_act |=> !latch_out_o)
      else $error("reset alone did not clear output");

   AST_SET_DOM: assert property (@(posedge clk_i) disable iff (srst_i)
      cycle_i && block_run_i && set_act && rst_act |=> latch_out_o && state_o == 8'h09)
      else $error("set did not dominate reset");

   AST_HOLD: assert property (@(posedge clk_i) disable iff (srst_i)
      cycle_i && block_run_i && !set_act && !rst_act |=> $stable(latch_out_o))
      else $error("output changed with both inputs inactive");

   AST_HOLD_CODE: assert property (@(posedge clk_i) disable iff (srst_i)
      cycle_i && block_run_i && !set_act && !rst_act |=> state_o == (latch_out_o ? 8'h09 : 8'h03))
      else $error("hold state code does not follow output");

   AST_NC_INV: assert property (@(posedge clk_i) disable iff (srst_i)
      en_q[`SDL_CH_SET] && nc_q[`SDL_CH_SET] |-> set_act == !set_i)
      else $error("break contact set input not inverted");

   AST_DIS_ZERO: assert property (@(posedge clk_i) disable iff (srst_i)
      !en_q[`SDL_CH_RST] |-> !rst_act)
      else $error("disabled reset input seen active");

   AST_DIS_SET: assert property (@(posedge clk_i) disable iff (srst_i)
      !en_q[`SDL_CH_SET] |-> !set_act)
      else $error("disabled set input seen active");

   AST_DEF_DIS: assert property (@(posedge clk_i)
      srst_i |=> en_q == 2'h0)
      else $error("inputs enabled after defaults");

   AST_UNDEF_RST: assert property (@(posedge clk_i)
      srst_i |=> state_o == 8'h00 && !latch_out_o)
      else $error("reset did not clear state and output");

   AST_STOP: assert property (@(posedge clk_i) disable iff (srst_i)
      cycle_i && !block_run_i |=> !latch_out_o && state_o == 8'h02)
      else $error("stop did not force safe output");

   AST_SAFE: assert property (@(posedge clk_i) disable iff (srst_i)
      cycle_i && block_run_i && rst_act && !set_act |=> state_o == 8'h03)
      else $error("safe state code missing");

   AST_SET_CODE: assert property (@(posedge clk_i) disable iff (srst_i)
      cycle_i && block_run_i && set_act |=> state_o == 8'h09)
      else $error("set state code missing");

   AST_DIAG: assert property (@(posedge clk_i) disable iff (srst_i)
      ##1 diag_o == 16'h0000 && img_diag_o == 16'h0000)
      else $error("diagnostic word not zero");

   AST_NO_ERR: assert property (@(posedge clk_i) disable iff (srst_i)
      ##1 !error_o)
      else $error("error output raised");

   AST_IMG: assert property (@(posedge clk_i) disable iff (srst_i)
      !map_state_q |=> img_state_o == 8'h00 && !img_state_vld_o)
      else $error("state word exposed while not mapped");

   AST_IMG_MAP: assert property (@(posedge clk_i) disable iff (srst_i)
      map_state_q |=> img_state_o == $past(state_o) && img_state_vld_o)
      else $error("mapped state word not copied to image");

   AST_RETAIN: assert property (@(posedge clk_i) disable iff (srst_i)
      !cycle_i |=> $stable(latch_out_o) && $stable(state_o))
      else $error("latch changed outside logic cycle");

endmodule

// >>> verilog/sdl_cfg.svh
// constants for the set-dominant safety latch: channel slots, reset values
`ifndef SDL_CFG_SVH
`define SDL_CFG_SVH

// =====================================================================
// channel slots in the two-wide input vectors
`define SDL_CH_SET 0
`define SDL_CH_RST 1
`define SDL_NUM_CH 2

// =====================================================================
// reset values
`define SDL_CFG_EN_RST 2'h0
`define SDL_CFG_NC_RST 2'h0
`define SDL_OUT_RST 1'b0
`define SDL_DIAG_RST 16'h0000
`define SDL_ERR_RST 1'b0

`endif

// >>> verilog/sdl_pkg.sv
// types shared by the set-dominant safety latch modules
package sdl_pkg;

   // =====================================================================
   // state codes reported on the 8-bit state word
   typedef enum logic [7:0] {
      SDL_ST_UNDEF = 8'b0000_0000,
      SDL_ST_STOP  = 8'b0000_0010,
      SDL_ST_SAFE  = 8'b0000_0011,
      SDL_ST_SET   = 8'b0000_1001
   } sdl_state_e;

   typedef logic [15:0] sdl_diag_t;

endpackage

// >>> verilog/sdl_chan_if.sv
// carrier between latch core and input conditioner
`timescale 1ns/1ns
interface sdl_chan_if;
   logic [1:0] raw;
   logic [1:0] en;
   logic [1:0] nc;
   logic [1:0] act;

   // conditioner side
   modport cond (
      input raw,
      input en,
      input nc,
      output act
   );

   // core side
   modport core (
      output raw,
      output en,
      output nc,
      input act
   );
endinterface

// >>> verilog/sdl_in_cond.sv
// input conditioner: enable and contact polarity for both latch inputs
`timescale 1ns/1ns
`include "sdl_cfg.svh"
module sdl_in_cond (
   sdl_chan_if.cond ch
);

   // disabled reads as 0, break contact is inverted before use
   function automatic logic cond_bit(input logic raw, input logic en, input logic nc);
      cond_bit = en & (raw ^ nc);
   endfunction

   // =====================================================================
   // one conditioner per channel
   genvar g;
   generate
      for (g = 0; g < `SDL_NUM_CH; g++) begin : g_ch
         assign ch.act[g] = cond_bit(ch.raw[g], ch.en[g], ch.nc[g]);
      end
   endgenerate

endmodule

// >>> dv/sdl_src_model.sv
// partner model: linked safe inputs wired through make or break contacts
`timescale 1ns/1ns
module sdl_src_model (
   // logical demand from the linked source
   input wire logic set_lvl_i,
   input wire logic reset_lvl_i,
   // contact kind of each link, 1 = break contact
   input wire logic set_nc_i,
   input wire logic reset_nc_i,
   // raw levels seen on the wires
   output logic set_o,
   output logic reset_o
);
   // =====================================================================
   // contact wiring
   // a break contact opens when demanded, so the wire carries the inverse
   assign set_o = set_lvl_i ^ set_nc_i;
   assign reset_o = reset_lvl_i ^ reset_nc_i;
endmodule

// >>> dv/sdl_latch_top_tb.sv
// self-checking testbench for the set-dominant safety latch
`timescale 1ns/1ns
module sdl_latch_top_tb;
   // =====================================================================
   // stimulus and observation
   logic clk, srst, s_lvl, r_lvl, cfg_load, s_en, s_nc, r_en, r_nc, ms, md, run, cyc, s_raw, r_raw;
   logic out, err, sv, dv;
   logic [7:0] st, ist;
   logic [15:0] dg, idg;
   int num_errors, comparisons;

   // partner model turns logical demand into contact levels
   sdl_src_model i_src (.set_lvl_i(s_lvl), .reset_lvl_i(r_lvl), .set_nc_i(s_nc), .reset_nc_i(r_nc),
      .set_o(s_raw), .reset_o(r_raw));

   sdl_latch_top i_dut (.clk_i(clk), .srst_i(srst), .set_i(s_raw), .reset_i(r_raw), .cfg_load_i(cfg_load),
      .set_en_i(s_en), .set_nc_i(s_nc), .reset_en_i(r_en), .reset_nc_i(r_nc), .expose_state_word_i(ms),
      .expose_diag_word_i(md), .block_run_i(run), .cycle_i(cyc), .latch_out_o(out), .state_o(st),
      .diag_o(dg), .error_o(err), .img_state_o(ist), .img_diag_o(idg), .img_state_vld_o(sv),
      .img_diag_vld_o(dv));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task results;
      if (num_errors == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // config word is {set_en, set_nc, reset_en, reset_nc, map_state, map_diag}
   task cfg(input logic [5:0] c);
      @(posedge clk);
      {s_en, s_nc, r_en, r_nc, ms, md} <= c;
      cfg_load <= 1'b1;
      @(posedge clk);
      cfg_load <= 1'b0;
   endtask

   // one logic cycle, then the result and the image one clock later
   task eval(input logic rn, input logic sl, input logic rl, input logic eo, input logic [7:0] es);
      @(posedge clk);
      run <= rn;
      s_lvl <= sl;
      r_lvl <= rl;
      cyc <= 1'b1;
      @(posedge clk);
      cyc <= 1'b0;
      #1;
      chk({15'h0, out}, {15'h0, eo});
      chk({8'h00, st}, {8'h00, es});
      @(posedge clk);
      #1;
      chk({8'h00, ist}, {8'h00, (ms ? es : 8'h00)});
      chk({14'h0000, sv, dv}, {14'h0000, ms, md});
      chk(dg | idg, 16'h0000);
      chk({15'h0000, err}, 16'h0000);
   endtask

   // =====================================================================
   // watchdog: the sequence needs well under two thousand clocks
   initial begin
      #200000;
      num_errors++;
      results();
   end

   initial begin
      {srst, s_lvl, r_lvl, cfg_load, s_en, s_nc, r_en, r_nc, ms, md, run, cyc} = 12'h800;
      num_errors = 0;
      comparisons = 0;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      #1;
      chk({8'h00, st}, {8'h00, sdl_pkg::SDL_ST_UNDEF});
      eval(1'b1, 1'b1, 1'b1, 1'b0, sdl_pkg::SDL_ST_SAFE);
      cfg(6'b101010);
      eval(1'b1, 1'b1, 1'b0, 1'b1, sdl_pkg::SDL_ST_SET);
      eval(1'b1, 1'b0, 1'b0, 1'b1, sdl_pkg::SDL_ST_SET);
      eval(1'b1, 1'b0, 1'b1, 1'b0, sdl_pkg::SDL_ST_SAFE);
      eval(1'b1, 1'b1, 1'b1, 1'b1, sdl_pkg::SDL_ST_SET);
      eval(1'b0, 1'b1, 1'b0, 1'b0, sdl_pkg::SDL_ST_STOP);
      // run input moves without a cycle strobe: nothing may change
      @(posedge clk);
      run <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk({15'h0, out}, 16'h0000);
      chk({8'h00, st}, {8'h00, sdl_pkg::SDL_ST_STOP});
      // holding a cleared output after stop reports the safe code
      eval(1'b1, 1'b0, 1'b0, 1'b0, sdl_pkg::SDL_ST_SAFE);
      cfg(6'b111101);
      eval(1'b1, 1'b1, 1'b0, 1'b1, sdl_pkg::SDL_ST_SET);
      eval(1'b1, 1'b0, 1'b1, 1'b0, sdl_pkg::SDL_ST_SAFE);
      cfg(6'b100000);
      eval(1'b1, 1'b1, 1'b0, 1'b1, sdl_pkg::SDL_ST_SET);
      eval(1'b1, 1'b0, 1'b1, 1'b1, sdl_pkg::SDL_ST_SET);
      // second reset mid-run clears latch and configuration
      @(posedge clk);
      srst <= 1'b1;
      {s_en, s_nc, r_en, r_nc, ms, md} <= 6'h00;
      @(posedge clk);
      srst <= 1'b0;
      #1;
      chk({7'h00, out, st}, 16'h0000);
      eval(1'b1, 1'b1, 1'b0, 1'b0, sdl_pkg::SDL_ST_SAFE);
      results();
   end
endmodule
